//--- bench/rfs_card.sv
// partner: card side of the link as seen through the demodulator events
`timescale 1ns/1ps
module rfs_card import rfs_pkg::*; (
	input wire logic clk_i,
	output rfs_rx_event_type ev_o
);
	initial ev_o = '0;
	// one event word per cycle; every pulse lasts exactly one cycle
	task automatic pulse(input rfs_rx_event_type e);
		@(posedge clk_i);
		ev_o <= e;
	endtask
	// start, n bits with collision at k, error kind err before bit ep, done
	task automatic frame(input int n, input int k, input int err, input int ep);
		rfs_rx_event_type x;
		x = '0;
		x.rx_start = 1'b1;
		pulse(x);
		for (int i = 0; i <= n; i++) begin
			x = '0;
			x.parity_bad = (i == ep && err == 1);
			x.crc_bad = (i == ep && err == 2);
			x.stop_bad = (i == ep && err == 3);
			x.sof_eof_bad = (i == ep && err == 4);
			x.count_bad = (i == ep && err == 5);
			if (x != '0) pulse(x);
			x = '0;
			x.data_bit = (i < n);
			x.bit_value = i[0];
			x.collision = (i == k);
			if (i < n) pulse(x);
		end
		x = '0;
		x.rx_done = 1'b1;
		pulse(x);
		pulse('0);
	endtask
endmodule // rfs_card

//--- bench/rfs_tracker_asserts.sv
// checker: port-level assertions of the receive outcome tracker
`timescale 1ns/1ps
module rfs_tracker_asserts import rfs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [9:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire rfs_rx_event_type rx_event_i,
	input wire logic collision_capable_mode_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic collision_index_valid_o,
	input wire logic receive_done_event_o,
	input wire logic receive_halted_o
);
	// ----
	// frame-in-progress tracking
	// ----
	logic recv_q;
	wire logic fault_w = rx_event_i.stop_bad | rx_event_i.sof_eof_bad | rx_event_i.count_bad;
	wire logic mapped_w = (paddr_i == RFS_OUTCOME_ADDR) | (paddr_i == RFS_CTRL_ADDR);
	wire logic rd_out_w = pready_o & ~pwrite_i & (paddr_i == RFS_OUTCOME_ADDR);
	wire logic recv_d = rx_event_i.rx_start | (recv_q & ~rx_event_i.rx_done);
	wire logic refused_w = pslverr_o & (pwrite_i | (prdata_o == 32'h0000_0000));
	wire logic fault_mid_w = recv_q & fault_w & ~rx_event_i.rx_start & ~rx_event_i.rx_done;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			recv_q <= 1'b0;
		end else begin
			recv_q <= recv_d;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// properties
	// ----
	chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	chk_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without setup");
	chk_unmapped_err: assert property (pready_o && !mapped_w |-> refused_w)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (pready_o && mapped_w |-> !pslverr_o)
		else $error("mapped access refused");
	chk_reserved_zero: assert property (rd_out_w |-> prdata_o[31:26] == 6'h00)
		else $error("reserved bits not zero");
	chk_halt_fault: assert property (fault_mid_w |=> receive_halted_o)
		else $error("no halt after framing fault");
	chk_halt_clear: assert property (rx_event_i.rx_start |=> !receive_halted_o)
		else $error("halt kept over new frame");
	chk_done_pulse: assert property (recv_q && rx_event_i.rx_done |=> receive_done_event_o)
		else $error("done event missing");
	chk_done_cause: assert property (receive_done_event_o |-> $past(rx_event_i.rx_done))
		else $error("done event without cause");
	chk_valid_clear: assert property (rx_event_i.rx_start |=> !collision_index_valid_o)
		else $error("index valid kept over new frame");
	chk_valid_cause: assert property ($rose(collision_index_valid_o) |-> $past(rx_event_i.collision))
		else $error("index valid without collision");
endmodule // rfs_tracker_asserts
bind rfs_tracker rfs_tracker_asserts chk (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.rx_event_i, .collision_capable_mode_i, .prdata_o, .pready_o, .pslverr_o, .collision_index_valid_o,
	.receive_done_event_o, .receive_halted_o);

//--- bench/rfs_tracker_bench.sv
// testbench: random frames against an integer model of the outcome word
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module rfs_tracker_bench import rfs_pkg::*; ();
	logic clk_i, rst_i, psel, penable, pwrite, ccm, pready, pslverr, civ, e, done_ev, halted;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, r, seed;
	rfs_rx_event_type ev;
	int errors, samples_checked, a, n, k, err, ep, mult, inv, cm, nb, fr, cw, cap, coll;
	int par, d0, h0, dones, halts;
	rfs_tracker dut (.clk_i, .rst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .rx_event_i(ev), .collision_capable_mode_i(ccm), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .collision_index_valid_o(civ), .receive_done_event_o(done_ev),
		.receive_halted_o(halted));
	rfs_card card (.clk_i, .ev_o(ev));
	// done pulses and halted cycles as the design shows them
	always @(posedge clk_i) begin
		dones <= dones + int'(done_ev === 1'b1);
		halts <= halts + int'(halted === 1'b1);
	end
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	function automatic int rnd(int m);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed[15:0]) % m;
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----
	// apb master: request held until pready seen at an edge
	// ----
	task automatic apb(input logic w, input logic [9:0] ad, input logic [31:0] d);
		int t;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20) begin
			errors++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		{rst_i, psel, penable, pwrite, ccm} = 5'b10000;
		paddr = '0;
		pwdata = '0;
		seed = 32'h0000_baef;
		errors = 0;
		samples_checked = 0;
		fr = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b1, RFS_OUTCOME_ADDR, 32'hffff_ffff);
		apb(1'b0, RFS_OUTCOME_ADDR, 32'h0000_0000);
		`CHK("outcome word", RFS_OUTCOME_RESET, r)
		apb(1'b0, 10'h3f0, 32'h0000_0000);
		`CHK("unmapped error", 1'b1, e)
		for (int i = 0; i < 18; i++) begin
			a = rnd(8);
			n = 1 + rnd(40);
			k = rnd(n + 8);
			err = i % 6;
			ep = 1 + rnd(n);
			mult = rnd(2);
			inv = rnd(2);
			cm = rnd(2);
			par = rnd(2);
			ccm <= rnd(2) == 1;
			cw = (cm << 14) | (inv << 13) | (mult << 12) | (par << 10) | (a << 6);
			apb(1'b1, RFS_CTRL_ADDR, cw);
			apb(1'b0, RFS_CTRL_ADDR, 32'h0000_0000);
			`CHK("control word", cw, r)
			// pin passes a synchroniser, so let it settle first
			repeat (6) @(posedge clk_i);
			d0 = dones;
			h0 = halts;
			card.frame(n, k, err, ep);
			nb = (err >= 3) ? ep : n;
			fr = mult ? (fr + 1) % 16 : 0;
			coll = k < nb;
			cap = cm | int'(ccm);
			apb(1'b0, RFS_OUTCOME_ADDR, 32'h0000_0000);
			`CHK("collision seen", coll, r[18])
			if (coll && cap) `CHK("collision index", a + k, r[25:19])
			`CHK("index valid", coll && cap, civ)
			`CHK("framing fault", err >= 3, r[17])
			`CHK("check fault", err == 2 || (err == 1 && par && !inv), r[16])
			`CHK("done events", 1, dones - d0)
			`CHK("halt seen", err >= 3, halts > h0)
			`CHK("last bits", (a + nb) % 8, r[15:13])
			if (mult) `CHK("frame tally", fr, r[12:9])
			`CHK("byte tally", (a + nb + 7) / 8, r[8:0])
		end
		results();
	end
endmodule // rfs_tracker_bench

//--- shared/rfs_pkg.sv
// package: register map, field layout and event types of the receive outcome tracker
package rfs_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	// printed offsets are not all multiples of four: index kept, byte address is four times it
	localparam logic [7:0] RFS_OUTCOME_IDX = 8'h13;
	localparam logic [7:0] RFS_CTRL_IDX = 8'h20;
	localparam logic [9:0] RFS_OUTCOME_ADDR = {RFS_OUTCOME_IDX, 2'b00};
	localparam logic [9:0] RFS_CTRL_ADDR = {RFS_CTRL_IDX, 2'b00};
	localparam logic [31:0] RFS_OUTCOME_RESET = 32'h0000_0000;
	localparam logic [31:0] RFS_CTRL_RESET = 32'h0000_0000;
	// ----------------------------------------
	// outcome word fields
	// ----------------------------------------
	localparam int RFS_COLL_POS_LSB = 19;
	localparam int RFS_COLL_SEEN_BIT = 18;
	localparam int RFS_FRAME_FAULT_BIT = 17;
	localparam int RFS_CHECK_FAULT_BIT = 16;
	localparam int RFS_LAST_BITS_LSB = 13;
	localparam int RFS_FRAMES_LSB = 9;
	localparam int RFS_BYTES_LSB = 0;
	localparam int RFS_COLL_POS_W = 7;
	localparam int RFS_LAST_BITS_W = 3;
	localparam int RFS_FRAMES_W = 4;
	localparam int RFS_BYTES_W = 9;
	// ----------------------------------------
	// control word fields (software settings)
	// ----------------------------------------
	localparam int RFS_CTL_ALIGN_LSB = 6;
	localparam int RFS_CTL_ALIGN_W = 3;
	localparam int RFS_CTL_PARITY_BIT = 10;
	localparam int RFS_CTL_MULTI_BIT = 12;
	localparam int RFS_CTL_INVPAR_BIT = 13;
	localparam int RFS_CTL_COLLMODE_BIT = 14;
	localparam logic [31:0] RFS_CTRL_MASK = 32'h0000_75C0;

	// events from the demodulator, one-cycle pulses
	typedef struct packed {
		logic rx_start;
		logic rx_done;
		logic data_bit;
		logic bit_value;
		logic byte_end;
		logic parity_bad;
		logic crc_bad;
		logic collision;
		logic stop_bad;
		logic sof_eof_bad;
		logic count_bad;
	} rfs_rx_event_type;

	typedef enum logic [1:0] {
		RFS_IDLE = 2'b00,
		RFS_RECV = 2'b01,
		RFS_HALT = 2'b11
	} rfs_state_type;
endpackage

//--- src/rfs_apb_slave.sv
// apb slave decode for outcome and control words
`timescale 1ns/1ps
module rfs_apb_slave import rfs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [9:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] outcome_i,
	output logic [31:0] ctrl_o,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic setup_w = psel_i & ~penable_i;
	wire logic hit_out_w = (paddr_i == RFS_OUTCOME_ADDR);
	wire logic hit_ctl_w = (paddr_i == RFS_CTRL_ADDR);
	wire logic [31:0] rdata_w = hit_out_w ? outcome_i : (hit_ctl_w ? ctrl_o : 32'h0000_0000);
	wire logic err_w = ~(hit_out_w | hit_ctl_w);
	wire logic access_w = psel_i & penable_i & pready_o;
	// ----------------------------------------
	// access: one wait-free answer, ready in the access phase
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_o <= RFS_CTRL_RESET;
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup_w;
			pslverr_o <= setup_w & err_w;
			if (setup_w & ~pwrite_i) begin
				prdata_o <= rdata_w;
			end
			// outcome word writes dropped: read-only; a write lands only at the access edge
			if (access_w & pwrite_i & hit_ctl_w) begin
				ctrl_o <= pwdata_i & RFS_CTRL_MASK;
			end
		end
	end
endmodule // rfs_apb_slave

//--- src/rfs_sync3.sv
// three-flop synchroniser with agreement filter for an external level
`timescale 1ns/1ps
module rfs_sync3 (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_o <= 1'b0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// change counted only once stages two and three agree
			if (s2_q == s3_q) begin
				q_o <= s3_q;
			end
		end
	end
endmodule // rfs_sync3

//--- src/rfs_tracker.sv
// receive outcome tracker: per-frame collision, fault and tally status word
// Notes on behaviour
// - first collision data-bit index reported in seven-bit field.
// - index meaningful only in collision-capable modes while index-valid is set.
// - nonzero first-bit offset is added into the collision index.
// - collision-seen flag set on any collision during reception.
// - framing fault on bad stop bit, bad start/end of frame, wrong count.
// - after a framing fault, further data of the frame is ignored.
// - framing and check faults clear when next reception begins.
// - check fault on parity or checksum mismatch; reception continues.
// - inverted-parity end criterion does not raise the check fault.
// - valid bits of final byte in three bits, zero meaning all eight.
// - frame tally updated on receive done; valid with multi-frame capture.
// - byte tally valid from receive done until receiver enabled again.
// - first-bit offset sets storage position of first received bit.
// - per-byte parity enabled and bad parity raises check fault, continuing.
`timescale 1ns/1ps
module rfs_tracker import rfs_pkg::*; #(
	parameter int COLL_W = RFS_COLL_POS_W,
	parameter int BYTES_W = RFS_BYTES_W,
	parameter int FRAMES_W = RFS_FRAMES_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [9:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire rfs_rx_event_type rx_event_i,
	input wire logic collision_capable_mode_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic collision_index_valid_o,
	output logic receive_done_event_o,
	output logic receive_halted_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	rfs_state_type state_q;
	rfs_state_type state_d;
	logic [COLL_W-1:0] first_collision_bit_index_q;
	logic [COLL_W-1:0] bit_pos_q;
	logic coll_seen_q;
	logic frame_fault_q;
	logic check_fault_q;
	logic [2:0] last_bits_q;
	logic [FRAMES_W-1:0] frames_q;
	logic [BYTES_W-1:0] bytes_q;
	logic [BYTES_W-1:0] bytes_live_q;
	logic [2:0] bits_in_byte_q;
	logic [31:0] ctrl_w;
	logic [31:0] outcome_w;
	logic mode_sync_w;

	// ----------------------------------------
	// settings
	// ----------------------------------------
	wire logic [2:0] align_w = ctrl_w[RFS_CTL_ALIGN_LSB +: RFS_CTL_ALIGN_W];
	wire logic parity_on_w = ctrl_w[RFS_CTL_PARITY_BIT];
	wire logic multi_frame_capture_on = ctrl_w[RFS_CTL_MULTI_BIT];
	wire logic inv_parity_stop_w = ctrl_w[RFS_CTL_INVPAR_BIT];
	// mode strap may come from a pin, so it is synchronised
	wire logic coll_mode_w = ctrl_w[RFS_CTL_COLLMODE_BIT] | mode_sync_w;

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	wire logic receiving_w = (state_q == RFS_RECV);
	wire logic frame_err_w = receiving_w & (rx_event_i.stop_bad | rx_event_i.sof_eof_bad
		| rx_event_i.count_bad);
	// wrong parity is the stop criterion when inverted-parity end is set
	wire logic par_err_w = parity_on_w & rx_event_i.parity_bad & ~inv_parity_stop_w;
	wire logic check_err_w = receiving_w & (par_err_w | rx_event_i.crc_bad);
	wire logic data_w = receiving_w & rx_event_i.data_bit & ~frame_err_w;
	wire logic coll_w = data_w & rx_event_i.collision;
	wire logic first_coll_w = coll_w & ~coll_seen_q;
	// offset counted as pre-filled bits of the first byte
	wire logic [COLL_W-1:0] align_ext_w = COLL_W'(align_w);
	wire logic [2:0] bits_next_w = bits_in_byte_q + 3'd1;

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			RFS_IDLE: begin
				if (rx_event_i.rx_start) begin
					state_d = RFS_RECV;
				end
			end
			RFS_RECV: begin
				if (rx_event_i.rx_done) begin
					state_d = RFS_IDLE;
				end else if (frame_err_w) begin
					state_d = RFS_HALT;
				end
			end
			RFS_HALT: begin
				if (rx_event_i.rx_done) begin
					state_d = RFS_IDLE;
				end
			end
			default: begin
				state_d = RFS_IDLE;
			end
		endcase
		// a new start always wins; restarts capture cleanly
		if (rx_event_i.rx_start) begin
			state_d = RFS_RECV;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= RFS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	// a start opens a new frame; an error in that same cycle belonged to the old one
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			coll_seen_q <= 1'b0;
		end else if (rx_event_i.rx_start) begin
			coll_seen_q <= 1'b0;
		end else if (coll_w) begin
			coll_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_fault_q <= 1'b0;
		end else if (rx_event_i.rx_start) begin
			frame_fault_q <= 1'b0;
		end else if (frame_err_w) begin
			frame_fault_q <= 1'b1;
		end
	end

	// reception goes on after a check fault, so later data still counts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			check_fault_q <= 1'b0;
		end else if (rx_event_i.rx_start) begin
			check_fault_q <= 1'b0;
		end else if (check_err_w) begin
			check_fault_q <= 1'b1;
		end
	end

	// only the first collision of a frame is kept
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			first_collision_bit_index_q <= '0;
		end else if (rx_event_i.rx_start) begin
			first_collision_bit_index_q <= '0;
		end else if (first_coll_w) begin
			first_collision_bit_index_q <= bit_pos_q;
		end
	end

	// index valid only in a mode where a collision position means something
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			collision_index_valid_o <= 1'b0;
		end else if (rx_event_i.rx_start) begin
			collision_index_valid_o <= 1'b0;
		end else if (first_coll_w) begin
			collision_index_valid_o <= coll_mode_w;
		end
	end

	// ----------------------------------------
	// bit and byte tallies
	// ----------------------------------------
	// saturates: an index past seven bits cannot be shown
	wire logic bit_pos_full_w = (bit_pos_q == {COLL_W{1'b1}});
	wire logic byte_wrap_w = data_w & (bits_next_w == 3'd0);
	// a done with no frame in progress is a stray pulse and is dropped
	wire logic done_w = rx_event_i.rx_done & (state_q != RFS_IDLE);
	// partial byte counts as one, its valid bits reported
	wire logic [BYTES_W-1:0] bytes_final_w = bytes_live_q + BYTES_W'(bits_in_byte_q != 3'd0);

	// position of the next data bit; starts at the first-bit offset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_pos_q <= '0;
		end else if (rx_event_i.rx_start) begin
			bit_pos_q <= align_ext_w;
		end else if (data_w & ~bit_pos_full_w) begin
			bit_pos_q <= bit_pos_q + COLL_W'(1);
		end
	end

	// the offset pre-fills the first byte
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bits_in_byte_q <= 3'd0;
		end else if (rx_event_i.rx_start) begin
			bits_in_byte_q <= align_w;
		end else if (data_w) begin
			bits_in_byte_q <= bits_next_w;
		end
	end

	// whole bytes only; the partial one is added when the frame ends
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bytes_live_q <= '0;
		end else if (rx_event_i.rx_start) begin
			bytes_live_q <= '0;
		end else if (byte_wrap_w) begin
			bytes_live_q <= bytes_live_q + BYTES_W'(1);
		end
	end

	// tally stale once receiver enabled again; a done in the start cycle still closes the old frame
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bytes_q <= '0;
		end else if (done_w) begin
			bytes_q <= bytes_final_w;
		end else if (rx_event_i.rx_start) begin
			bytes_q <= '0;
		end
	end

	// zero when the last byte is whole
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_bits_q <= 3'd0;
		end else if (done_w) begin
			last_bits_q <= bits_in_byte_q;
		end
	end

	// not cleared on start: the tally runs across the frames of one capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			frames_q <= '0;
		end else if (done_w) begin
			if (multi_frame_capture_on) begin
				frames_q <= frames_q + FRAMES_W'(1);
			end else begin
				frames_q <= '0;
			end
		end
	end

	// one-cycle pulse, one clock after the done that closed a frame
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			receive_done_event_o <= 1'b0;
		end else begin
			receive_done_event_o <= done_w;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			receive_halted_o <= 1'b0;
		end else begin
			receive_halted_o <= (state_d == RFS_HALT);
		end
	end

	// ----------------------------------------
	// outcome word assembly, reserved bits zero
	// ----------------------------------------
	assign outcome_w = {6'h00, first_collision_bit_index_q, coll_seen_q, frame_fault_q, check_fault_q,
		last_bits_q, frames_q, bytes_q};

	rfs_sync3 u_mode_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(collision_capable_mode_i),
		.q_o(mode_sync_w)
	);

	rfs_apb_slave u_apb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.outcome_i(outcome_w),
		.ctrl_o(ctrl_w),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o)
	);
endmodule // rfs_tracker
